// file: trc_defines.svh
// constants for the reinitialization and tcp retry controller
// assumes a 20 mhz reference clock and 16-bit buffer memory words
`ifndef TRC_DEFINES_SVH
`define TRC_DEFINES_SVH

`define TRC_CLK_PERIOD_NS   50
`define TRC_TIMER_UNIT_MS   500

`define TRC_ADR_OWN_IP_LO   16'h000A
`define TRC_ADR_OWN_IP_HI   16'h000B
`define TRC_ADR_ULP_TIMER   16'h000C
`define TRC_ADR_RESEND_TMR  16'h000D
`define TRC_ADR_END_TIMER   16'h000E
`define TRC_ADR_REINIT      16'h001F
`define TRC_ADR_OP_SETTING  16'h0020
`define TRC_ADR_SPEED_MODE  16'h0021
`define TRC_ADR_INIT_ERR    16'h0069
`define TRC_ADR_OPEN_STAT   16'h5000

`define TRC_REINIT_BIT      15

`define TRC_RST_ULP         16'h003C
`define TRC_RST_RESEND      16'h0014
`define TRC_RST_END         16'h003C
`define TRC_RST_OWN_IP      32'hC0A8_0001

`define TRC_ERR_NONE        16'h0000
`define TRC_ERR_BAD_IP      16'hC000
`define TRC_ERR_BAD_TIMER   16'hC001

`define TRC_MSS_LOCAL       16'h05B4
`define TRC_MSS_ROUTER      16'h0218

`define TRC_PEER_DEPTH      4
`define TRC_FIFO_DEPTH      8
`define TRC_FIFO_WIDTH      16

`endif

// file: trc_pkg.sv
// types shared by the reinitialization controller
// assumes trc_defines.svh supplies the numeric constants
package trc_pkg;

    typedef enum logic [2:0] {
        ST_READY  = 3'b001,
        ST_REQ    = 3'b010,
        ST_CLEAR  = 3'b011,
        ST_LOAD   = 3'b100,
        ST_FAILED = 3'b101
    } trc_rst_state_t;

    typedef enum logic [1:0] {
        SS_IDLE = 2'b00,
        SS_WAIT = 2'b01
    } trc_snd_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } trc_bus_req_t;

    typedef struct packed {
        logic [31:0] own_ip;
        logic [15:0] op_setting;
        logic [15:0] speed_mode;
    } trc_reinit_par_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] ip;
        logic [47:0] mac;
    } trc_peer_t;

endpackage : trc_pkg

// file: trc_reinit_ctrl.sv
// reinitialization controller with tcp segmentation, retry and peer table
// assumes a host driving the buffer port and instruction strobe synchronously
// What the document requires
// RL1: local line: one segment to 1460, else two
// RL2: router: 536 per segment, up to three
// RL3: retry count is ulp timer over resend
// RL4: resend per timer expiry, then report send error
// RL5: equal timers mean no retries at all
// RL6: reinit returns to post-startup state, no cpu reset
// RL7: keep peer ip/mac pairs, reinit clears them
// RL8: reinit applies new ip, operation, speed settings
// RL9: host requests only while init done set; code also accepts in the failed state
// RL10: host closes all connections before requesting
// RL11: accepted request drops init done flag
// RL12: completion clears word 1f b15, raises done
// RL13: failed reinit stores initial error code
// RL14: host never mixes instruction and direct write
// RL15: direct write: settings first, then request
// RL16: open completion status readable at 5000
// RL17: no new request while one runs
// RL18: reinit loads timer and other parameters
// RL19: direct write sets word 1f bit 15
`timescale 1ns/1ps
`include "trc_defines.svh"

module trc_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    input  wire logic         ref_clk_i,
    input  wire logic         reset_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    always_comb begin
        push = in_valid_i && (cnt_q != (AW+1)'(D));
        pop  = (cnt_q != '0) && out_ready_i;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    assign in_ready_o  = (cnt_q != (AW+1)'(D));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
endmodule : trc_fifo

module trc_reinit_ctrl #(
    parameter int unsigned TICK_CYCLES =
        `TRC_TIMER_UNIT_MS * 1000000 / `TRC_CLK_PERIOD_NS
) (
    input  wire logic                   ref_clk_i,
    input  wire logic                   reset_i,
    input  wire trc_pkg::trc_bus_req_t  bus_i,
    output logic [15:0]                 bus_rdata_o,
    input  wire logic                   reinit_instruction_i,
    input  wire trc_pkg::trc_reinit_par_t reinit_par_i,
    output logic                        reinit_cmp_o,
    output logic                        reinit_fail_o,
    output logic                        init_done_flag_o,
    output logic [31:0]                 own_ip_o,
    output logic [15:0]                 op_setting_o,
    output logic [15:0]                 speed_mode_o,
    input  wire logic [15:0]            open_status_i,
    input  wire logic                   peer_learn_i,
    input  wire logic                   peer_chk_i,
    input  wire trc_pkg::trc_peer_t     peer_i,
    output logic                        peer_reject_o,
    input  wire logic                   send_start_i,
    input  wire logic [15:0]            send_len_i,
    input  wire logic                   via_router_i,
    input  wire logic                   ack_i,
    output logic [1:0]                  seg_count_o,
    output logic                        seg_tx_o,
    output logic                        send_done_o,
    output logic                        send_err_o,
    input  wire logic                   tx_valid_i,
    input  wire logic [15:0]            tx_data_i,
    output logic                        tx_ready_o,
    output logic                        link_valid_o,
    output logic [15:0]                 link_data_o,
    input  wire logic                   link_ready_i
);
    import trc_pkg::*;

    trc_rst_state_t st_q, st_d;
    logic [15:0] ip_lo_q, ip_lo_d, ip_hi_q, ip_hi_d, ulp_q, ulp_d, rsd_q, rsd_d;
    logic [15:0] end_q, end_d, reinit_q, reinit_d, opset_q, opset_d, speed_q, speed_d;
    logic [15:0] err_q, err_d, retries_q, retries_d, act_rsd_q, act_rsd_d;
    logic [31:0] act_ip_q, act_ip_d;
    logic [15:0] act_op_q, act_op_d, act_sp_q, act_sp_d;
    logic        done_q, done_d, inst_q, inst_d, cmp_q, cmp_d, fail_q, fail_d;
    logic        cfg_ok, req_write, accept;
    logic [31:0] new_ip;

    // reinitialization sequence and buffer words
    always_comb begin
        st_d = st_q;
        ip_lo_d = ip_lo_q;
        ip_hi_d = ip_hi_q;
        ulp_d = ulp_q;
        rsd_d = rsd_q;
        end_d = end_q;
        reinit_d = reinit_q;
        opset_d = opset_q;
        speed_d = speed_q;
        err_d = err_q;
        retries_d = retries_q;
        act_rsd_d = act_rsd_q;
        act_ip_d = act_ip_q;
        act_op_d = act_op_q;
        act_sp_d = act_sp_q;
        done_d = done_q;
        inst_d = inst_q;
        cmp_d = 1'b0;
        fail_d = 1'b0;
        new_ip = {ip_hi_q, ip_lo_q};
        cfg_ok = (new_ip != '0) && (new_ip != '1) && (rsd_q != '0) && (ulp_q >= rsd_q);
        // a rising write of b15 is the direct request
        req_write = bus_i.wr && (bus_i.addr == `TRC_ADR_REINIT)
                    && bus_i.wdata[`TRC_REINIT_BIT] && !reinit_q[`TRC_REINIT_BIT]; // see RL19
        accept = (st_q == ST_READY || st_q == ST_FAILED)
                 && (reinit_instruction_i || req_write);
        if (bus_i.wr) begin
            case (bus_i.addr)
                `TRC_ADR_OWN_IP_LO:  ip_lo_d = bus_i.wdata;
                `TRC_ADR_OWN_IP_HI:  ip_hi_d = bus_i.wdata;
                `TRC_ADR_ULP_TIMER:  ulp_d = bus_i.wdata;
                `TRC_ADR_RESEND_TMR: rsd_d = bus_i.wdata;
                `TRC_ADR_END_TIMER:  end_d = bus_i.wdata;
                `TRC_ADR_REINIT:     reinit_d = bus_i.wdata;
                `TRC_ADR_OP_SETTING: opset_d = bus_i.wdata;
                `TRC_ADR_SPEED_MODE: speed_d = bus_i.wdata;
                default: ;
            endcase
        end
        case (st_q)
            ST_READY, ST_FAILED: begin
                if (accept) begin
                    done_d = 1'b0; // see RL11
                    st_d = ST_REQ;
                    inst_d = reinit_instruction_i;
                    if (reinit_instruction_i) begin
                        {ip_hi_d, ip_lo_d} = reinit_par_i.own_ip;
                        opset_d = reinit_par_i.op_setting;
                        speed_d = reinit_par_i.speed_mode;
                        reinit_d[`TRC_REINIT_BIT] = 1'b1;
                    end
                end
            end
            ST_REQ:   st_d = ST_CLEAR;
            ST_CLEAR: st_d = ST_LOAD;
            ST_LOAD: begin
                reinit_d[`TRC_REINIT_BIT] = 1'b0; // see RL12
                cmp_d = inst_q;
                inst_d = 1'b0;
                if (cfg_ok) begin
                    // new addressing and line settings take effect here
                    act_ip_d = new_ip; // see RL8
                    act_op_d = opset_q;
                    act_sp_d = speed_q;
                    act_rsd_d = rsd_q; // see RL18
                    // equal timers give zero retries instead of one
                    retries_d = (ulp_q == rsd_q) ? 16'h0000 : ulp_q / rsd_q; // see RL3 see RL5
                    err_d = `TRC_ERR_NONE;
                    done_d = 1'b1; // see RL12
                    st_d = ST_READY;
                end else begin
                    err_d = (rsd_q == '0 || ulp_q < rsd_q) ? `TRC_ERR_BAD_TIMER
                                                          : `TRC_ERR_BAD_IP; // see RL13
                    fail_d = inst_q;
                    st_d = ST_FAILED;
                end
            end
            default: st_d = ST_LOAD;
        endcase
        // a host write of b15 wins over the hardware clear
        if (req_write) begin
            reinit_d[`TRC_REINIT_BIT] = 1'b1;
        end
    end

    // reset runs the initial process; later requests repeat it without a reset
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_q <= ST_LOAD; // see RL6
            ip_lo_q <= 16'(`TRC_RST_OWN_IP);
            ip_hi_q <= 16'(`TRC_RST_OWN_IP >> 16);
            ulp_q <= `TRC_RST_ULP;
            rsd_q <= `TRC_RST_RESEND;
            end_q <= `TRC_RST_END;
            reinit_q <= '0;
            opset_q <= '0;
            speed_q <= '0;
            err_q <= `TRC_ERR_NONE;
            retries_q <= '0;
            act_rsd_q <= `TRC_RST_RESEND;
            act_ip_q <= '0;
            act_op_q <= '0;
            act_sp_q <= '0;
            done_q <= 1'b0;
            inst_q <= 1'b0;
            cmp_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ip_lo_q <= ip_lo_d;
            ip_hi_q <= ip_hi_d;
            ulp_q <= ulp_d;
            rsd_q <= rsd_d;
            end_q <= end_d;
            reinit_q <= reinit_d;
            opset_q <= opset_d;
            speed_q <= speed_d;
            err_q <= err_d;
            retries_q <= retries_d;
            act_rsd_q <= act_rsd_d;
            act_ip_q <= act_ip_d;
            act_op_q <= act_op_d;
            act_sp_q <= act_sp_d;
            done_q <= done_d;
            inst_q <= inst_d;
            cmp_q <= cmp_d;
            fail_q <= fail_d;
        end
    end

    // registered read port, one cycle latency
    logic [15:0] rdata_q, rdata_d;
    always_comb begin
        rdata_d = rdata_q;
        if (bus_i.rd) begin
            case (bus_i.addr)
                `TRC_ADR_OWN_IP_LO:  rdata_d = ip_lo_q;
                `TRC_ADR_OWN_IP_HI:  rdata_d = ip_hi_q;
                `TRC_ADR_ULP_TIMER:  rdata_d = ulp_q;
                `TRC_ADR_RESEND_TMR: rdata_d = rsd_q;
                `TRC_ADR_END_TIMER:  rdata_d = end_q;
                `TRC_ADR_REINIT:     rdata_d = reinit_q;
                `TRC_ADR_OP_SETTING: rdata_d = opset_q;
                `TRC_ADR_SPEED_MODE: rdata_d = speed_q;
                `TRC_ADR_INIT_ERR:   rdata_d = err_q;
                `TRC_ADR_OPEN_STAT:  rdata_d = open_status_i; // see RL16
                default:             rdata_d = '0;
            endcase
        end
    end

    // peer ip/mac pairs used to reject spoofed access
    trc_peer_t peer_q [`TRC_PEER_DEPTH];
    trc_peer_t peer_d [`TRC_PEER_DEPTH];
    logic      rej_q, rej_d, known, placed;
    always_comb begin
        peer_d = peer_q;
        rej_d = 1'b0;
        known = 1'b0;
        placed = 1'b0;
        for (int i = 0; i < `TRC_PEER_DEPTH; i++) begin
            if (peer_q[i].valid && peer_q[i].ip == peer_i.ip) begin
                known = 1'b1;
                if (peer_chk_i && peer_q[i].mac != peer_i.mac) begin
                    rej_d = 1'b1; // see RL7
                end
            end
        end
        // a full table keeps its oldest pairs; newcomers are not tracked
        if (peer_learn_i && !known) begin
            for (int i = 0; i < `TRC_PEER_DEPTH; i++) begin
                if (!placed && !peer_q[i].valid) begin
                    peer_d[i] = peer_i;
                    peer_d[i].valid = 1'b1;
                    placed = 1'b1;
                end
            end
        end
        if (st_q == ST_CLEAR) begin
            for (int i = 0; i < `TRC_PEER_DEPTH; i++) begin
                peer_d[i].valid = 1'b0; // see RL7
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < `TRC_PEER_DEPTH; i++) begin
                peer_q[i] <= '0;
            end
            rej_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            peer_q <= peer_d;
            rej_q <= rej_d;
            rdata_q <= rdata_d;
        end
    end

    // send engine: segmentation, resend timer and retry count
    trc_snd_state_t ss_q, ss_d;
    logic [23:0] tick_q, tick_d;
    logic [15:0] unit_q, unit_d, retry_q, retry_d;
    logic [1:0]  seg_q, seg_d;
    logic        tx_q, tx_d, sdone_q, sdone_d, serr_q, serr_d, tick;
    always_comb begin
        ss_d = ss_q;
        unit_d = unit_q;
        retry_d = retry_q;
        seg_d = seg_q;
        tx_d = 1'b0;
        sdone_d = 1'b0;
        serr_d = 1'b0;
        tick = (tick_q == 24'(TICK_CYCLES - 1));
        tick_d = tick ? '0 : tick_q + 1'b1;
        case (ss_q)
            SS_IDLE: begin
                if (send_start_i && done_q) begin
                    if (via_router_i) begin
                        seg_d = (send_len_i <= `TRC_MSS_ROUTER) ? 2'd1 :
                                (send_len_i <= 16'(2 * `TRC_MSS_ROUTER)) ? 2'd2 : 2'd3; // see RL2
                    end else begin
                        seg_d = (send_len_i <= `TRC_MSS_LOCAL) ? 2'd1 : 2'd2; // see RL1
                    end
                    tx_d = 1'b1;
                    retry_d = '0;
                    unit_d = '0;
                    tick_d = '0;
                    ss_d = SS_WAIT;
                end
            end
            SS_WAIT: begin
                if (!done_q) begin
                    ss_d = SS_IDLE;
                end else if (ack_i) begin
                    sdone_d = 1'b1;
                    ss_d = SS_IDLE;
                end else if (tick) begin
                    if (unit_q + 16'd1 >= act_rsd_q) begin
                        unit_d = '0;
                        if (retry_q < retries_q) begin
                            retry_d = retry_q + 16'd1;
                            tx_d = 1'b1; // see RL4
                        end else begin
                            serr_d = 1'b1; // see RL4
                            ss_d = SS_IDLE;
                        end
                    end else begin
                        unit_d = unit_q + 16'd1;
                    end
                end
            end
            default: ss_d = SS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ss_q <= SS_IDLE;
            tick_q <= '0;
            unit_q <= '0;
            retry_q <= '0;
            seg_q <= '0;
            tx_q <= 1'b0;
            sdone_q <= 1'b0;
            serr_q <= 1'b0;
        end else begin
            ss_q <= ss_d;
            tick_q <= tick_d;
            unit_q <= unit_d;
            retry_q <= retry_d;
            seg_q <= seg_d;
            tx_q <= tx_d;
            sdone_q <= sdone_d;
            serr_q <= serr_d;
        end
    end

    // payload buffer; the link drains only while the module is initialized
    logic fifo_valid;
    trc_fifo #(.W(`TRC_FIFO_WIDTH), .D(`TRC_FIFO_DEPTH)) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (tx_valid_i),
        .in_data_i   (tx_data_i),
        .in_ready_o  (tx_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (link_data_o),
        .out_ready_i (link_ready_i && done_q)
    );

    assign link_valid_o     = fifo_valid && done_q;
    assign bus_rdata_o      = rdata_q;
    assign reinit_cmp_o     = cmp_q;
    assign reinit_fail_o    = fail_q;
    assign init_done_flag_o = done_q;
    assign own_ip_o         = act_ip_q;
    assign op_setting_o     = act_op_q;
    assign speed_mode_o     = act_sp_q;
    assign peer_reject_o    = rej_q;
    assign seg_count_o      = seg_q;
    assign seg_tx_o         = tx_q;
    assign send_done_o      = sdone_q;
    assign send_err_o       = serr_q;

    sequence s_accept;
        accept;
    endsequence
    // the release edge still shows the reset-held load state; not a finish yet
    sequence s_finish_ok;
        (st_q == ST_LOAD) && cfg_ok && !reset_i;
    endsequence

    property p_seg_local;
        @(posedge ref_clk_i) disable iff (reset_i)
        (ss_q == SS_IDLE && send_start_i && done_q && !via_router_i)
        |=> (seg_count_o == ($past(send_len_i) <= 16'h05B4 ? 2'd1 : 2'd2));
    endproperty
    a_seg_local: assert property (p_seg_local) else $error("local segment count wrong"); // see RL1
    property p_seg_router;
        @(posedge ref_clk_i) disable iff (reset_i)
        (ss_q == SS_IDLE && send_start_i && done_q && via_router_i
         && send_len_i > 16'h0430 && send_len_i <= 16'h0648) |=> seg_count_o == 2'd3;
    endproperty
    a_seg_router: assert property (p_seg_router) else $error("router segment count wrong"); // see RL2
    property p_retry_calc;
        @(posedge ref_clk_i) disable iff (reset_i)
        (s_finish_ok and (ulp_q == 16'h003C && rsd_q == 16'h0014)) |=> retries_q == 16'd3;
    endproperty
    a_retry_calc: assert property (p_retry_calc) else $error("retry count not ulp over resend"); // see RL3
    property p_err_exhaust;
        @(posedge ref_clk_i) disable iff (reset_i)
        send_err_o |-> $past(retry_q == retries_q) && ss_q == SS_IDLE;
    endproperty
    a_err_exhaust: assert property (p_err_exhaust) else $error("send error before retries spent"); // see RL4
    property p_peer_clear;
        @(posedge ref_clk_i) disable iff (reset_i)
        st_q == ST_CLEAR |=> !peer_q[0].valid && !peer_q[`TRC_PEER_DEPTH-1].valid;
    endproperty
    a_peer_clear: assert property (p_peer_clear) else $error("peer table kept across reinit"); // see RL7
    property p_done_drop;
        @(posedge ref_clk_i) disable iff (reset_i)
        s_accept |=> !init_done_flag_o [*3];
    endproperty
    a_done_drop: assert property (p_done_drop) else $error("init done stayed high on request"); // see RL11
    property p_done_raise;
        @(posedge ref_clk_i) disable iff (reset_i)
        (s_finish_ok and !req_write) |=> init_done_flag_o && !reinit_q[`TRC_REINIT_BIT]
                                         && own_ip_o == $past(new_ip);
    endproperty
    a_done_raise: assert property (p_done_raise) else $error("completion not reported"); // see RL12
    property p_fail_code;
        @(posedge ref_clk_i) disable iff (reset_i)
        (st_q == ST_LOAD && !cfg_ok) |=> err_q != 16'h0000 && !init_done_flag_o;
    endproperty
    a_fail_code: assert property (p_fail_code) else $error("failed reinit left no error code"); // see RL13
    property p_open_stat;
        @(posedge ref_clk_i) disable iff (reset_i)
        (bus_i.rd && bus_i.addr == 16'h5000) |=> bus_rdata_o == $past(open_status_i);
    endproperty
    a_open_stat: assert property (p_open_stat) else $error("open status word misread"); // see RL16
endmodule : trc_reinit_ctrl

// file: trc_link_sink.sv
// link-side consumer of the controller's tx fifo output
// assumes the controller clock; the bench stalls it via stall_i
`timescale 1ns/1ps
module trc_link_sink (
    input  wire logic        ref_clk_i,
    input  wire logic        stall_i,
    input  wire logic        valid_i,
    input  wire logic [15:0] data_i,
    output logic             ready_o
);
    logic [15:0] got[$];
    // ready lags stall by a cycle, as a registered consumer would
    always_ff @(posedge ref_clk_i) ready_o <= !stall_i;
    always @(posedge ref_clk_i) if (valid_i && ready_o) got.push_back(data_i);
endmodule : trc_link_sink

// file: testbench.sv
// self-checking bench for the reinitialization and tcp retry controller
// assumes a short timer tick and the link sink model on the fifo output
`timescale 1ns/1ps
module testbench;
    import trc_pkg::*;
    logic ref_clk_i = 0, reset_i = 1, stall = 1, inst = 0, learn = 0, pchk = 0;
    logic start = 0, rt = 0, ack = 0, txv = 0, cmp, fail, done, rej, stx, sdone, serr;
    logic txr, lnkv, lnkr;
    trc_bus_req_t    bus_i = '0;
    trc_reinit_par_t par   = '0;
    trc_peer_t       peer  = '0;
    logic [15:0] len = '0, txd = '0, ostat = 16'h0003, rd, rdata, opset, spd, lnkd;
    logic [31:0] ip;
    logic [1:0]  segc;
    int fails = 0, compares = 0;

    trc_reinit_ctrl #(.TICK_CYCLES(4)) i_dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus_i(bus_i), .bus_rdata_o(rdata),
        .reinit_instruction_i(inst), .reinit_par_i(par), .reinit_cmp_o(cmp),
        .reinit_fail_o(fail), .init_done_flag_o(done), .own_ip_o(ip),
        .op_setting_o(opset), .speed_mode_o(spd), .open_status_i(ostat),
        .peer_learn_i(learn), .peer_chk_i(pchk), .peer_i(peer), .peer_reject_o(rej),
        .send_start_i(start), .send_len_i(len), .via_router_i(rt), .ack_i(ack),
        .seg_count_o(segc), .seg_tx_o(stx), .send_done_o(sdone), .send_err_o(serr),
        .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr), .link_valid_o(lnkv),
        .link_data_o(lnkd), .link_ready_i(lnkr));
    trc_link_sink i_sink (.ref_clk_i(ref_clk_i), .stall_i(stall), .valid_i(lnkv),
        .data_i(lnkd), .ready_o(lnkr));

    initial forever #25 ref_clk_i = ~ref_clk_i;

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    task automatic acc(input logic [15:0] a, input logic w, input logic [15:0] d);
        @(posedge ref_clk_i);
        bus_i <= '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge ref_clk_i);
        bus_i <= '0;
        @(posedge ref_clk_i);
        rd = rdata;
    endtask : acc
    task automatic wflag(input logic want, input int lim);
        int n;
        for (n = 0; n < lim && done !== want; n++) @(posedge ref_clk_i);
        if (n == lim) begin
            check(done, want);
            end_sim();
        end
    endtask : wflag
    // counts (re)sends until done or error; a acks the first send
    task automatic send(input logic [15:0] l, input logic r, input logic a, output int tx);
        int n;
        tx = 0;
        @(posedge ref_clk_i);
        {start, len, rt} <= {1'b1, l, r};
        @(posedge ref_clk_i);
        start <= 0;
        for (n = 0; n < 500 && serr !== 1 && sdone !== 1; n++) begin
            @(posedge ref_clk_i);
            ack <= a && stx;
            tx += stx;
        end
        if (n == 500) begin
            check(n, 0);
            end_sim();
        end
    endtask : send
    task automatic probe(input logic [47:0] m, output logic r);
        @(posedge ref_clk_i);
        {peer, pchk} <= {1'b1, 32'h0A00_0005, m, 1'b1};
        @(posedge ref_clk_i);
        pchk <= 0;
        r = 0;
        repeat (3) begin
            @(posedge ref_clk_i);
            r |= rej;
        end
    endtask : probe

    task automatic t_init();
        wflag(1, 20);
        acc(16'h000C, 0, 0); check(rd, 16'h003C);
        acc(16'h5000, 0, 0); check(rd, ostat);
        acc(16'h7777, 0, 0); check(rd, 16'h0000);
    endtask : t_init
    task automatic t_seg();
        int l[7] = '{1460, 1461, 536, 537, 1072, 1073, 1608};
        int e[7] = '{1, 2, 1, 2, 2, 3, 3};
        int tx;
        for (int i = 0; i < 7; i++) begin
            send(l[i], i > 1, 1, tx);
            check(segc, e[i]);
            check(tx, 1);
        end
    endtask : t_seg
    task automatic t_retry();
        int tx;
        send(16'd100, 0, 0, tx); check(tx, 4);
    endtask : t_retry
    task automatic t_reinit();
        logic r;
        int tx;
        ostat <= '0;
        peer <= '{valid: 1, ip: 32'h0A00_0005, mac: 48'h0000_0000_0011};
        @(posedge ref_clk_i) learn <= 1;
        @(posedge ref_clk_i) learn <= 0;
        probe(48'h0000_0000_0022, r); check(r, 1);
        acc(16'h000A, 1, 16'h0002);
        acc(16'h000B, 1, 16'hC0A8);
        acc(16'h0020, 1, 16'h1234);
        acc(16'h0021, 1, 16'h0005);
        acc(16'h000C, 1, 16'h0014);
        acc(16'h000E, 1, 16'h0014);
        acc(16'h001F, 1, 16'h8000);
        wflag(0, 5);
        wflag(1, 20);
        acc(16'h001F, 0, 0); check(rd[15], 0);
        check(ip, 32'hC0A8_0002);
        check({opset, spd}, 32'h1234_0005);
        probe(48'h0000_0000_0022, r); check(r, 0);
        send(16'd100, 0, 0, tx); check(tx, 1);
    endtask : t_reinit
    task automatic t_fail();
        logic c = 0, f = 0;
        acc(16'h000A, 1, 0);
        acc(16'h000B, 1, 0);
        acc(16'h001F, 1, 16'h8000);
        repeat (10) @(posedge ref_clk_i);
        check(done, 0);
        acc(16'h0069, 0, 0); check(rd, 16'hC000);
        // requests are also accepted in the failed state; this test recovers the failed module by reset
        reset_i <= 1;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 0;
        wflag(1, 20);
        check(ip, 32'hC0A8_0001);
        par <= '{own_ip: 32'hC0A8_0003, op_setting: 16'h0001, speed_mode: 16'h0002};
        @(posedge ref_clk_i) inst <= 1;
        @(posedge ref_clk_i) inst <= 0;
        repeat (8) begin
            @(posedge ref_clk_i);
            {c, f} |= {cmp, fail};
        end
        check({c, f, done}, 3'b101);
        check({ip, spd}, 48'hC0A8_0003_0002);
    endtask : t_fail
    task automatic t_fifo();
        int p = 0;
        {txv, txd} <= {1'b1, 16'h0A00};
        repeat (12) begin
            @(posedge ref_clk_i);
            if (txr) begin
                p++;
                txd <= 16'(16'h0A00 + p);
            end
        end
        txv <= 0;
        check(p, 8);
        stall <= 0;
        repeat (20) @(posedge ref_clk_i);
        check(i_sink.got.size(), 8);
        foreach (i_sink.got[i]) check(i_sink.got[i], 16'h0A00 + i);
    endtask : t_fifo

    initial begin
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 0;
        t_init();
        t_seg();
        t_retry();
        t_reinit();
        t_fail();
        t_fifo();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        check(0, 1);
        end_sim();
    end
endmodule : testbench
